// ### common/remote_map_pkg.sv
// Constants for the remote target map and link status register bank
package remote_map_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONTROL = 8'h04;
  localparam logic [7:0] IDX_TARGET = 8'h07;
  localparam logic [7:0] IDX_ALIAS = 8'h08;
  localparam logic [7:0] IDX_CNT_LOW = 8'h0A;
  localparam logic [7:0] IDX_CNT_HIGH = 8'h0B;
  localparam logic [7:0] IDX_STATUS = 8'h0C;
  localparam logic [7:0] IDX_PORT_VIEW = 8'h20;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h22;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h23;
  // Field positions
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int CTRL_CRC_RESET_BIT = 5;
  localparam int PORT_VIEW_BIT = 0;
  localparam int STAT_SELFTEST_BIT = 3;
  localparam int STAT_PCLK_BIT = 2;
  localparam int STAT_NORMAL_BIT = 1;
  localparam int STAT_LINK_BIT = 0;
  // Interrupt status bits
  localparam int IRQ_LINK0_BIT = 0;
  localparam int IRQ_LINK1_BIT = 1;
  localparam int IRQ_CRC0_BIT = 2;
  localparam int IRQ_CRC1_BIT = 3;
  localparam int IRQ_WIDTH = 4;
  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [6:0] RST_TARGET = 7'h00;
  localparam logic [6:0] RST_ALIAS = 7'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [3:0] RST_IRQ = 4'h0;
  localparam logic [6:0] ADDR_DISABLED = 7'h00;
  localparam int PORT_COUNT = 2;
  localparam int PADDR_WIDTH = 12;

  function automatic logic [PADDR_WIDTH-1:0] byteAddr(input logic [7:0] idx);
    byteAddr = {2'h0, idx, 2'h0};
  endfunction
endpackage

// ### core/remote_map_regs.sv
// APB register bank: remote target mapping, CRC error counting, link status
//
// Contract
// RULE1 - Hold target address, substitute into aliased transactions
// RULE2 - Hold alias; matching local transaction gets remapped
// RULE3 - Zero target or alias disables forwarding
// RULE4 - Sixteen-bit CRC counter, low and high bytes
// RULE5 - Counter cleared while CRC reset bit set
// RULE6 - Status bit 3 flags self-test CRC errors
// RULE7 - Self-test flag cleared: link loss, restart, reset
// RULE8 - Status bit 2 shows valid pixel clock
// RULE9 - Pixel clock flag held until invalid clock
// RULE10 - Status bit 1 flags normal CRC errors
// RULE11 - Normal flag cleared on link loss, reset bit
// RULE12 - Status bit 0 shows cable link presence
// RULE13 - Port select shows second port's state
// RULE14 - CRC reset bit holds value, not self-clearing
// RULE15 - Reserved bits read zero, writes ignored
// RULE16 - Counter increments per bad frame, saturates
`timescale 1ns/1ps
`default_nettype none
module remote_map_regs #(
  parameter int COUNT_WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [remote_map_pkg::PADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] linkDetect,
  input wire logic [1:0] crcFrameError,
  input wire logic [1:0] selftestActive,
  input wire logic [1:0] selftestStart,
  input wire logic pclkValid,
  input wire logic pclkInvalid,
  input wire logic i2cReqValid,
  input wire logic [6:0] i2cReqAddr,
  output logic [1:0] fwdValid,
  output logic [6:0] fwdAddr0,
  output logic [6:0] fwdAddr1,
  output logic irq
);

  if (COUNT_WIDTH < 9 || COUNT_WIDTH > 16)
  begin : gen_width_check
    $error("COUNT_WIDTH must lie in 9..16");
  end

  localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = {COUNT_WIDTH{1'b1}};

  logic [7:0] control;
  logic portView;
  logic [6:0] tgtAddr [remote_map_pkg::PORT_COUNT];
  logic [6:0] aliasAddr [remote_map_pkg::PORT_COUNT];
  logic [COUNT_WIDTH-1:0] crcCount [remote_map_pkg::PORT_COUNT];
  logic [1:0] selftestFlag;
  logic [1:0] normalFlag;
  logic [1:0] linkPrev;
  logic pclkFlag;
  logic [remote_map_pkg::IRQ_WIDTH-1:0] irqStatus;
  logic [remote_map_pkg::IRQ_WIDTH-1:0] irqEnable;
  logic [remote_map_pkg::IRQ_WIDTH-1:0] irqEvent;
  logic crcReset;
  logic [1:0] linkLoss;
  logic setupPhase;
  logic writeTaken;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [15:0] viewCount;

  function automatic logic hitReg(input logic [remote_map_pkg::PADDR_WIDTH-1:0] a,
                                  input logic [7:0] idx);
    hitReg = (a == remote_map_pkg::byteAddr(idx));
  endfunction

  function automatic logic remapHit(input logic [6:0] req, input logic [6:0] tgt,
                                    input logic [6:0] als);
    remapHit = (tgt != remote_map_pkg::ADDR_DISABLED) &&
               (als != remote_map_pkg::ADDR_DISABLED) && (req == als);
  endfunction

  assign crcReset = control[remote_map_pkg::CTRL_CRC_RESET_BIT];
  assign linkLoss = linkPrev & ~linkDetect;
  assign setupPhase = psel && !penable;
  assign writeTaken = psel && penable && pready && pwrite;
  assign viewCount = 16'(crcCount[portView]);
  assign irqEvent = {crcFrameError[1], crcFrameError[0], linkLoss[1] | (linkDetect[1] & ~linkPrev[1]),
                     linkLoss[0] | (linkDetect[0] & ~linkPrev[0])};

  // Read data and error answer
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (hitReg(paddr, remote_map_pkg::IDX_CONTROL))
    begin
      next_prdata[7:0] = control;
    end
    else if (hitReg(paddr, remote_map_pkg::IDX_TARGET))
    begin
      next_prdata[7:0] = {tgtAddr[portView], 1'b0}; // [RULE13] [RULE15]
    end
    else if (hitReg(paddr, remote_map_pkg::IDX_ALIAS))
    begin
      next_prdata[7:0] = {aliasAddr[portView], 1'b0}; // [RULE13] [RULE15]
    end
    else if (hitReg(paddr, remote_map_pkg::IDX_CNT_LOW))
    begin
      next_prdata[7:0] = viewCount[7:0]; // [RULE4]
    end
    else if (hitReg(paddr, remote_map_pkg::IDX_CNT_HIGH))
    begin
      next_prdata[7:0] = viewCount[15:8]; // [RULE4]
    end
    else if (hitReg(paddr, remote_map_pkg::IDX_STATUS))
    begin
      next_prdata[remote_map_pkg::STAT_SELFTEST_BIT] = selftestFlag[portView]; // [RULE6]
      next_prdata[remote_map_pkg::STAT_PCLK_BIT] = pclkFlag; // [RULE8]
      next_prdata[remote_map_pkg::STAT_NORMAL_BIT] = normalFlag[portView]; // [RULE10]
      next_prdata[remote_map_pkg::STAT_LINK_BIT] = linkDetect[portView]; // [RULE12]
    end
    else if (hitReg(paddr, remote_map_pkg::IDX_PORT_VIEW))
    begin
      next_prdata[remote_map_pkg::PORT_VIEW_BIT] = portView;
    end
    else if (hitReg(paddr, remote_map_pkg::IDX_IRQ_STATUS))
    begin
      next_prdata[remote_map_pkg::IRQ_WIDTH-1:0] = irqStatus;
    end
    else if (hitReg(paddr, remote_map_pkg::IDX_IRQ_ENABLE))
    begin
      next_prdata[remote_map_pkg::IRQ_WIDTH-1:0] = irqEnable;
    end
    else if (hitReg(paddr, remote_map_pkg::IDX_IRQ_CLEAR))
    begin
      next_prdata = 32'h0000_0000;
    end
    else
    begin
      next_pslverr = 1'b1;
    end
  end

  // APB answer one cycle after setup
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setupPhase)
    begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
    else
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // Control and port view; reset bit held as written
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      control <= remote_map_pkg::RST_CONTROL;
      portView <= 1'b0;
    end
    else if (writeTaken)
    begin
      if (hitReg(paddr, remote_map_pkg::IDX_CONTROL))
      begin
        control <= pwdata[7:0]; // [RULE14]
      end
      if (hitReg(paddr, remote_map_pkg::IDX_PORT_VIEW))
      begin
        portView <= pwdata[remote_map_pkg::PORT_VIEW_BIT];
      end
    end
  end

  // Target and alias per port
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int p = 0; p < remote_map_pkg::PORT_COUNT; p++)
      begin
        tgtAddr[p] <= remote_map_pkg::RST_TARGET;
        aliasAddr[p] <= remote_map_pkg::RST_ALIAS;
      end
    end
    else if (writeTaken)
    begin
      if (hitReg(paddr, remote_map_pkg::IDX_TARGET))
      begin
        tgtAddr[portView] <= pwdata[remote_map_pkg::ADDR_MSB:remote_map_pkg::ADDR_LSB]; // [RULE1]
      end
      if (hitReg(paddr, remote_map_pkg::IDX_ALIAS))
      begin
        aliasAddr[portView] <= pwdata[remote_map_pkg::ADDR_MSB:remote_map_pkg::ADDR_LSB]; // [RULE2]
      end
    end
  end

  // Alias remap toward each remote link
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      fwdValid <= 2'b00;
      fwdAddr0 <= remote_map_pkg::ADDR_DISABLED;
      fwdAddr1 <= remote_map_pkg::ADDR_DISABLED;
    end
    else
    begin
      fwdValid[0] <= i2cReqValid && remapHit(i2cReqAddr, tgtAddr[0], aliasAddr[0]); // [RULE3]
      fwdValid[1] <= i2cReqValid && remapHit(i2cReqAddr, tgtAddr[1], aliasAddr[1]); // [RULE3]
      fwdAddr0 <= tgtAddr[0]; // [RULE1]
      fwdAddr1 <= tgtAddr[1]; // [RULE1]
    end
  end

  // CRC error counters
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int p = 0; p < remote_map_pkg::PORT_COUNT; p++)
      begin
        crcCount[p] <= COUNT_WIDTH'(remote_map_pkg::RST_COUNT);
      end
    end
    else
    begin
      for (int p = 0; p < remote_map_pkg::PORT_COUNT; p++)
      begin
        if (crcReset)
        begin
          crcCount[p] <= '0; // [RULE5]
        end
        else if (crcFrameError[p] && crcCount[p] != COUNT_MAX)
        begin
          crcCount[p] <= crcCount[p] + 1'b1; // [RULE16]
        end
      end
    end
  end

  // Sticky CRC flags and link history
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      selftestFlag <= 2'b00;
      normalFlag <= 2'b00;
      linkPrev <= 2'b00;
    end
    else
    begin
      linkPrev <= linkDetect;
      for (int p = 0; p < remote_map_pkg::PORT_COUNT; p++)
      begin
        if (linkLoss[p] || selftestStart[p] || crcReset)
        begin
          selftestFlag[p] <= 1'b0; // [RULE7]
        end
        else if (crcFrameError[p] && selftestActive[p])
        begin
          selftestFlag[p] <= 1'b1; // [RULE6]
        end
        if (linkLoss[p] || crcReset)
        begin
          normalFlag[p] <= 1'b0; // [RULE11]
        end
        else if (crcFrameError[p] && !selftestActive[p])
        begin
          normalFlag[p] <= 1'b1; // [RULE10]
        end
      end
    end
  end

  // Pixel clock detect, held until an invalid clock
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pclkFlag <= 1'b0;
    end
    else if (pclkInvalid)
    begin
      pclkFlag <= 1'b0; // [RULE9]
    end
    else if (pclkValid)
    begin
      pclkFlag <= 1'b1; // [RULE8]
    end
  end

  // Interrupt status, enable and output; set beats clear
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      irqStatus <= remote_map_pkg::RST_IRQ;
      irqEnable <= remote_map_pkg::RST_IRQ;
      irq <= 1'b0;
    end
    else
    begin
      if (writeTaken && hitReg(paddr, remote_map_pkg::IDX_IRQ_CLEAR))
      begin
        irqStatus <= (irqStatus & ~pwdata[remote_map_pkg::IRQ_WIDTH-1:0]) | irqEvent;
      end
      else
      begin
        irqStatus <= irqStatus | irqEvent;
      end
      if (writeTaken && hitReg(paddr, remote_map_pkg::IDX_IRQ_ENABLE))
      begin
        irqEnable <= pwdata[remote_map_pkg::IRQ_WIDTH-1:0];
      end
      irq <= |(irqStatus & irqEnable);
    end
  end

  // Checks
  chk_remap_addr: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE1] [RULE2]
    i2cReqValid && remapHit(i2cReqAddr, tgtAddr[0], aliasAddr[0])
    |=> fwdValid[0] && fwdAddr0 == $past(tgtAddr[0]))
    else $error("remap to target address missing");

  chk_zero_disable: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE3]
    (tgtAddr[1] == 7'h00 || aliasAddr[1] == 7'h00) |=> !fwdValid[1])
    else $error("forwarding with zero target or alias");

  chk_count_clear: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE5]
    crcReset |=> crcCount[0] == '0 && crcCount[1] == '0)
    else $error("counter not cleared by reset bit");

  chk_count_step: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE16]
    !crcReset && crcFrameError[0] && crcCount[0] != COUNT_MAX
    |=> crcCount[0] == $past(crcCount[0]) + 1'b1)
    else $error("counter did not step by one");

  chk_count_sat: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE16]
    !crcReset && crcCount[0] == COUNT_MAX |=> crcCount[0] == COUNT_MAX)
    else $error("counter wrapped past all ones");

  chk_selftest_clear: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE7]
    linkLoss[0] || selftestStart[0] || crcReset |=> !selftestFlag[0])
    else $error("self-test flag not cleared");

  chk_normal_flag: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE10] [RULE11]
    !linkLoss[0] && !crcReset && crcFrameError[0] && !selftestActive[0]
    |=> normalFlag[0] ##1 (normalFlag[0] || $past(linkLoss[0] || crcReset)))
    else $error("normal CRC flag not sticky");

  chk_pclk_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE9]
    pclkFlag && !pclkInvalid |=> pclkFlag)
    else $error("pixel clock flag dropped without invalid clock");

  chk_apb_answer: assert property (@(posedge clk_sys) disable iff (!nrst)
    setupPhase |=> pready ##1 !pready || !penable)
    else $error("APB answer not one cycle after setup");

  chk_reserved_read: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE15]
    setupPhase && !pwrite && (hitReg(paddr, remote_map_pkg::IDX_TARGET) ||
    hitReg(paddr, remote_map_pkg::IDX_STATUS)) |=> prdata[31:8] == '0 &&
    (prdata[0] == 1'b0 || !hitReg($past(paddr), remote_map_pkg::IDX_TARGET)) &&
    (prdata[7:4] == '0 || !hitReg($past(paddr), remote_map_pkg::IDX_STATUS)))
    else $error("reserved bits not zero");

  chk_view_select: assert property (@(posedge clk_sys) disable iff (!nrst) // [RULE13]
    setupPhase && !pwrite && hitReg(paddr, remote_map_pkg::IDX_CNT_LOW)
    |=> prdata[7:0] == $past(viewCount[7:0]))
    else $error("count byte not from selected port");

  chk_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
    ##1 irq == $past(|(irqStatus & irqEnable)))
    else $error("interrupt level wrong");

endmodule
`default_nettype wire

// ### sim/remote_map_partner.sv
// Far-side model: link presence and back-channel CRC errors per port
`timescale 1ns/1ps
`default_nettype none
module remote_map_partner (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [1:0] linkUp,
  input wire logic [1:0] errReq,
  output logic [1:0] linkDetect,
  output logic [1:0] crcFrameError
);
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      linkDetect <= 2'h0;
      crcFrameError <= 2'h0;
    end
    else
    begin
      linkDetect <= linkUp;
      // Bad frames only arrive over a live link
      crcFrameError <= errReq & linkUp;
    end
  end
endmodule
`default_nettype wire

// ### sim/remote_map_regs_tb_top.sv
// Self-checking bench for the remote target map register bank
`timescale 1ns/1ps
`default_nettype none
module remote_map_regs_tb_top;
  localparam int CW = 9;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, irq;
  logic i2cReqValid, pclkValid, pclkInvalid;
  logic [remote_map_pkg::PADDR_WIDTH-1:0] paddr;
  logic [31:0] pwdata, prdata, rdv, errv;
  logic [1:0] linkDetect, crcFrameError, selftestActive, selftestStart, linkUp, errReq, fwdValid;
  logic [6:0] i2cReqAddr, fwdAddr0, fwdAddr1;
  logic [6:0] tgtA [2];
  logic [6:0] alsA [2];
  int n_mismatch, n_compared, seed, cyc, nErr;

  remote_map_regs #(.COUNT_WIDTH(CW)) u_remote_map_regs (.clk_sys, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .linkDetect, .crcFrameError,
    .selftestActive, .selftestStart, .pclkValid, .pclkInvalid, .i2cReqValid, .i2cReqAddr,
    .fwdValid, .fwdAddr0, .fwdAddr1, .irq);
  remote_map_partner u_remote_map_partner (.clk_sys, .nrst, .linkUp, .errReq, .linkDetect,
    .crcFrameError);

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] stat(input logic st, input logic pc, input logic nm,
    input logic lk);
    return {28'h0, st, pc, nm, lk};
  endfunction

  function automatic logic [15:0] satCount(input int n);
    return (n > (1 << CW) - 1) ? 16'((1 << CW) - 1) : 16'(n);
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdv = prdata;
    errv = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(nm, rdv, exp);
  endtask

  task automatic remap(input logic [6:0] a, input logic [1:0] exp);
    i2cReqValid <= 1'b1;
    i2cReqAddr <= a;
    @(posedge clk_sys);
    i2cReqValid <= 1'b0;
    @(posedge clk_sys);
    chk("fwdValid", {30'h0, fwdValid}, {30'h0, exp});
  endtask

  task automatic pulse(input logic [1:0] e, input int n);
    errReq <= e;
    repeat (n) @(posedge clk_sys);
    errReq <= 2'h0;
    repeat (4) @(posedge clk_sys);
  endtask

  task summarize;
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  initial
  begin
    {nrst, psel, penable, pwrite, i2cReqValid, pclkValid, pclkInvalid} = '0;
    {paddr, pwdata, i2cReqAddr, selftestActive, selftestStart, linkUp, errReq} = '0;
    seed = 5412;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rdc("target", remote_map_pkg::IDX_TARGET, 32'h0);
    rdc("alias", remote_map_pkg::IDX_ALIAS, 32'h0);
    rdc("cntHigh", remote_map_pkg::IDX_CNT_HIGH, 32'h0);
    rdc("status", remote_map_pkg::IDX_STATUS, 32'h0);
    apb(1'b0, 8'h3F, 8'h00);
    chk("unmapped", errv, 32'h1);
    $display("Test reset values done");
    for (int p = 0; p < 2; p++)
    begin
      tgtA[p] = 7'($random(seed)) | 7'h01;
      alsA[p] = (p == 0) ? (7'($random(seed)) | 7'h01) : (alsA[0] ^ 7'h02);
      apb(1'b1, remote_map_pkg::IDX_PORT_VIEW, 8'(p));
      apb(1'b1, remote_map_pkg::IDX_TARGET, {tgtA[p], 1'b1});
      apb(1'b1, remote_map_pkg::IDX_ALIAS, {alsA[p], 1'b1});
    end
    for (int p = 0; p < 2; p++)
    begin
      apb(1'b1, remote_map_pkg::IDX_PORT_VIEW, 8'(p));
      rdc("target", remote_map_pkg::IDX_TARGET, {24'h0, tgtA[p], 1'b0});
      rdc("alias", remote_map_pkg::IDX_ALIAS, {24'h0, alsA[p], 1'b0});
    end
    remap(alsA[0], 2'b01);
    chk("fwdAddr0", {25'h0, fwdAddr0}, {25'h0, tgtA[0]});
    remap(alsA[1], 2'b10);
    chk("fwdAddr1", {25'h0, fwdAddr1}, {25'h0, tgtA[1]});
    apb(1'b1, remote_map_pkg::IDX_PORT_VIEW, 8'h00);
    apb(1'b1, remote_map_pkg::IDX_TARGET, 8'h00);
    remap(alsA[0], 2'b00);
    apb(1'b1, remote_map_pkg::IDX_TARGET, {tgtA[0], 1'b0});
    apb(1'b1, remote_map_pkg::IDX_ALIAS, 8'h00);
    remap(7'h00, 2'b00);
    $display("Test remap done");
    linkUp <= 2'b11;
    nErr = 1 + ($random(seed) & 15);
    pulse(2'b01, nErr);
    rdc("cntLow", remote_map_pkg::IDX_CNT_LOW, {24'h0, 8'(satCount(nErr))});
    rdc("status", remote_map_pkg::IDX_STATUS, stat(0, 0, 1, 1));
    apb(1'b1, remote_map_pkg::IDX_IRQ_ENABLE, 8'h04);
    repeat (2) @(posedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, remote_map_pkg::IDX_IRQ_CLEAR, 8'h04);
    repeat (2) @(posedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h0);
    rdc("irqStatus", remote_map_pkg::IDX_IRQ_STATUS, 32'h3);
    pulse(2'b01, 600);
    rdc("cntLow", remote_map_pkg::IDX_CNT_LOW, {24'h0, 8'(satCount(nErr + 600))});
    rdc("cntHigh", remote_map_pkg::IDX_CNT_HIGH, {24'h0, 8'(satCount(nErr + 600) >> 8)});
    apb(1'b1, remote_map_pkg::IDX_PORT_VIEW, 8'h01);
    rdc("cntLow1", remote_map_pkg::IDX_CNT_LOW, 32'h0);
    pulse(2'b10, 3);
    rdc("cntLow1", remote_map_pkg::IDX_CNT_LOW, 32'h3);
    apb(1'b1, remote_map_pkg::IDX_PORT_VIEW, 8'h00);
    $display("Test counter done");
    apb(1'b1, remote_map_pkg::IDX_CONTROL, 8'h20);
    pulse(2'b01, 5);
    rdc("cntLow", remote_map_pkg::IDX_CNT_LOW, 32'h0);
    rdc("status", remote_map_pkg::IDX_STATUS, stat(0, 0, 0, 1));
    rdc("control", remote_map_pkg::IDX_CONTROL, 32'h20);
    apb(1'b1, remote_map_pkg::IDX_CONTROL, 8'h00);
    selftestActive <= 2'b01;
    pulse(2'b01, 1);
    rdc("status", remote_map_pkg::IDX_STATUS, stat(1, 0, 0, 1));
    selftestStart <= 2'b01;
    @(posedge clk_sys);
    selftestStart <= 2'b00;
    repeat (3) @(posedge clk_sys);
    rdc("status", remote_map_pkg::IDX_STATUS, stat(0, 0, 0, 1));
    pulse(2'b01, 1);
    selftestActive <= 2'b00;
    pulse(2'b01, 1);
    rdc("status", remote_map_pkg::IDX_STATUS, stat(1, 0, 1, 1));
    linkUp <= 2'b10;
    repeat (4) @(posedge clk_sys);
    rdc("status", remote_map_pkg::IDX_STATUS, stat(0, 0, 0, 0));
    $display("Test flags done");
    pclkValid <= 1'b1;
    @(posedge clk_sys);
    pclkValid <= 1'b0;
    repeat (12) @(posedge clk_sys);
    rdc("status", remote_map_pkg::IDX_STATUS, stat(0, 1, 0, 0));
    apb(1'b1, remote_map_pkg::IDX_PORT_VIEW, 8'h01);
    rdc("status1", remote_map_pkg::IDX_STATUS, stat(0, 1, 0, 1));
    apb(1'b1, remote_map_pkg::IDX_PORT_VIEW, 8'h00);
    pclkInvalid <= 1'b1;
    @(posedge clk_sys);
    pclkInvalid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rdc("status", remote_map_pkg::IDX_STATUS, stat(0, 0, 0, 0));
    $display("Test pixel clock done");
    summarize();
  end
endmodule
`default_nettype wire
